// *** hw/fine_grained_translation_invalidate.sv ***
// Fine-grained address-translation invalidate and ordering unit of a hart
//
// Functional notes
// - SINVAL removes exactly what a full SFENCE.VMA with same operands removes.
// - SINVAL is ordered only against SFENCE.VMA, HFENCE.VVMA/GVMA and the two ordering fences.
// - SFENCE.W.INVAL orders earlier visible stores before later SINVALs.
// - SFENCE.INVAL.IR makes earlier SINVALs complete before later page walks.
// - W.INVAL, SINVAL, INVAL.IR in order act as one SFENCE.VMA.
// - HINVAL.VVMA/GVMA behave as SINVAL when the hypervisor is present.
// - HINVAL.GVMA selects entries by guest machine tag, not address space id.
// - Invalidations in U-mode raise illegal-instruction.
// - SINVAL or HINVAL.GVMA in S/HS-mode with machine trap bit set is illegal.
// - HINVAL in VS/VU-mode and SINVAL in VU-mode raise virtual-instruction.
// - SINVAL in VS-mode with hypervisor trap bit set raises virtual-instruction.
// - Ordering fences: illegal in U-mode, virtual-instruction in VU-mode.
// - Ordering fences ignore both trap bits; always allowed in S and VS.
// - Pipelined build issues invalidations back to back, ordering at fences.
// - Simple build runs invalidations as full fences, ordering fences as no-ops.
`timescale 1ns/10ps

module fine_grained_translation_invalidate
	import fg_inval_pkg::*;
#(
	parameter bit PIPELINED = 1'b1,
	parameter bit HYP_PRESENT = 1'b1,
	parameter int VA_W = VA_WIDTH,
	parameter int ID_W = ID_WIDTH,
	parameter int MAX_OUT = MAX_OUTSTANDING
)
(
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic clkEn, // Freezes all state while low
	input wire logic opValid, // Pipeline presents an operation
	input wire logic [2:0] opCode, // Operation code
	input wire logic [1:0] privLevel, // Nominal privilege of the hart
	input wire logic virtMode, // Hart runs virtualised
	input wire logic machine_trap_vm_ops, // Machine trap bit for VM operations
	input wire logic hyp_trap_guest_vm_ops, // Hypervisor trap bit for guest VM ops
	input wire logic [VA_W-1:0] rs1Value, // Virtual address operand
	input wire logic rs1Zero, // rs1 names the zero register
	input wire logic [ID_W-1:0] rs2Value, // Identifier operand
	input wire logic rs2Zero, // rs2 names the zero register
	input wire logic storesDrained, // All earlier stores visible to page walker
	input wire logic invReady, // Translation caches accept an invalidation
	input wire logic invAck, // Translation caches finished one invalidation
	output logic opReady, // Unit accepts an operation
	output logic respValid, // One-cycle completion pulse
	output logic respIllegal, // Completion carries illegal-instruction trap
	output logic respVirtual, // Completion carries virtual-instruction trap
	output logic invValid, // Invalidation request to translation caches
	output logic [1:0] invKind, // Target translation stage
	output logic [VA_W-1:0] invAddr, // Virtual address to match
	output logic invAllAddr, // Match every address
	output logic [ID_W-1:0] invId, // Address space id or guest machine tag
	output logic invAllId, // Match every identifier
	output logic walkHold // Blocks implicit page-table accesses
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	localparam int CNT_W = $clog2(MAX_OUT + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MAX_OUT);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	function automatic logic isInval(input logic [2:0] op);
		isInval = (op == OP_SINVAL) || (op == OP_HINVAL_VVMA) || (op == OP_HINVAL_GVMA);
	endfunction

	function automatic logic isFull(input logic [2:0] op);
		isFull = (op == OP_SFENCE_VMA) || (op == OP_HFENCE_VVMA) || (op == OP_HFENCE_GVMA);
	endfunction

	function automatic logic isHyp(input logic [2:0] op);
		isHyp = (op == OP_HINVAL_VVMA) || (op == OP_HINVAL_GVMA) ||
			(op == OP_HFENCE_VVMA) || (op == OP_HFENCE_GVMA);
	endfunction

	// Trap check; returns {illegal, virtual}
	function automatic logic [1:0] trapCheck(input logic [2:0] op, input logic [1:0] pl,
		input logic v, input logic mTrap, input logic hTrap);
		logic sLike;
		logic gvLike;
		logic userV;
		logic userH;
		sLike = (op == OP_SINVAL) || (op == OP_SFENCE_VMA);
		gvLike = (op == OP_HINVAL_GVMA) || (op == OP_HFENCE_GVMA);
		userV = v && (pl == PRIV_U);
		userH = !v && (pl == PRIV_U);
		trapCheck = 2'h0;
		if (isHyp(op) && !HYP_PRESENT)
			trapCheck = 2'h2;
		else if (userH)
			trapCheck = 2'h2;
		else if ((op == OP_FENCE_W_INVAL) || (op == OP_FENCE_INVAL_IR))
			trapCheck = userV ? 2'h1 : 2'h0;
		else if (isHyp(op) && v)
			trapCheck = 2'h1;
		else if (sLike && userV)
			trapCheck = 2'h1;
		else if (sLike && v && (pl == PRIV_S) && hTrap)
			trapCheck = 2'h1;
		else if ((sLike || gvLike) && !v && (pl == PRIV_S) && mTrap)
			trapCheck = 2'h2;
	endfunction

	// Stage selected by an invalidation; in VS-mode SINVAL acts on the VS stage
	function automatic logic [1:0] kindOf(input logic [2:0] op, input logic v);
		if ((op == OP_HINVAL_GVMA) || (op == OP_HFENCE_GVMA))
			kindOf = KIND_G;
		else if ((op == OP_HINVAL_VVMA) || (op == OP_HFENCE_VVMA) || v)
			kindOf = KIND_VS;
		else
			kindOf = KIND_S;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Acceptance and next state

	state_t stateReg;
	state_t stateNext;
	logic [CNT_W-1:0] outCountReg;
	logic [1:0] trapNow;
	logic take;
	logic issueFire;
	logic needStores;
	logic needDrain;
	logic needIssue;
	logic needIssueReg;
	logic needDrainReg;

	assign take = clkEn && opValid && opReady;
	assign issueFire = invValid && invReady;
	assign trapNow = trapCheck(opCode, privLevel, virtMode, machine_trap_vm_ops,
		hyp_trap_guest_vm_ops);

	always_comb
	begin
		needIssue = isInval(opCode) || isFull(opCode);
		needStores = isFull(opCode) || (opCode == OP_FENCE_W_INVAL) ||
			(isInval(opCode) && !PIPELINED);
		needDrain = isFull(opCode) || (opCode == OP_FENCE_INVAL_IR) ||
			(isInval(opCode) && !PIPELINED);
		if (!PIPELINED && !needIssue)
		begin
			needStores = 1'b0;
			needDrain = 1'b0;
		end
	end

	always_comb
	begin
		stateNext = stateReg;
		unique case (stateReg)
			ST_IDLE:
			begin
				if (take)
				begin
					if (trapNow != 2'h0)
						stateNext = ST_RESP;
					else if (needStores)
						stateNext = ST_STORES;
					else if (needIssue)
						stateNext = ST_ISSUE;
					else if (needDrain)
						stateNext = ST_DRAIN;
					else
						stateNext = ST_RESP;
				end
			end
			ST_STORES:
			begin
				if (storesDrained)
					stateNext = needIssueReg ? ST_ISSUE : (needDrainReg ? ST_DRAIN : ST_RESP);
			end
			ST_ISSUE:
			begin
				if (issueFire)
					stateNext = needDrainReg ? ST_DRAIN : ST_RESP;
			end
			ST_DRAIN:
			begin
				if (outCountReg == '0)
					stateNext = ST_RESP;
			end
			ST_RESP:
				stateNext = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stateReg <= ST_IDLE;
		else if (clkEn)
			stateReg <= stateNext;
	end

	// Plans latched at acceptance; SINVAL waits on nothing else in pipelined mode
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			needIssueReg <= 1'b0;
			needDrainReg <= 1'b0;
		end
		else if (take)
		begin
			// The op code may change once taken, so the issue and drain steps of the plan are kept here
			needIssueReg <= needIssue;
			needDrainReg <= needDrain;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			opReady <= RST_READY;
		else if (clkEn)
			opReady <= (stateNext == ST_IDLE);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			respValid <= 1'b0;
			respIllegal <= 1'b0;
			respVirtual <= 1'b0;
		end
		else if (clkEn)
		begin
			respValid <= (stateNext == ST_RESP);
			if (take)
			begin
				respIllegal <= trapNow[1];
				respVirtual <= trapNow[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Invalidation request to the translation caches

	// Payload latched at acceptance and held stable while the request waits
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			invKind <= KIND_S;
			invAddr <= '0;
			invAllAddr <= 1'b0;
			invId <= '0;
			invAllId <= 1'b0;
		end
		else if (take && (needIssue == 1'b1))
		begin
			invKind <= kindOf(opCode, virtMode);
			invAddr <= rs1Value;
			invAllAddr <= rs1Zero;
			invId <= rs2Value;
			invAllId <= rs2Zero;
		end
	end

	// A full tracker stalls the request rather than losing an acknowledge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			invValid <= 1'b0;
		else if (clkEn)
			invValid <= (stateNext == ST_ISSUE) && !(issueFire && stateReg == ST_ISSUE) &&
				(outCountReg != CNT_MAX || invAck);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			outCountReg <= '0;
		else if (clkEn)
		begin
			if (issueFire && !invAck)
				outCountReg <= outCountReg + CNT_ONE;
			else if (!issueFire && invAck && outCountReg != '0)
				outCountReg <= outCountReg - CNT_ONE;
		end
	end

	// Page walks wait while an ordering fence drains outstanding invalidations
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			walkHold <= 1'b0;
		else if (clkEn)
			walkHold <= (stateNext == ST_DRAIN);
	end

endmodule

// *** hw/fg_inval_pkg.sv ***
// Shared encodings and constants for the fine-grained translation invalidate unit
package fg_inval_pkg;

	// Operation codes presented by the instruction pipeline
	localparam logic [2:0] OP_SINVAL = 3'h0;
	localparam logic [2:0] OP_HINVAL_VVMA = 3'h1;
	localparam logic [2:0] OP_HINVAL_GVMA = 3'h2;
	localparam logic [2:0] OP_FENCE_W_INVAL = 3'h3;
	localparam logic [2:0] OP_FENCE_INVAL_IR = 3'h4;
	localparam logic [2:0] OP_SFENCE_VMA = 3'h5;
	localparam logic [2:0] OP_HFENCE_VVMA = 3'h6;
	localparam logic [2:0] OP_HFENCE_GVMA = 3'h7;

	// Nominal privilege level (virtualisation is a separate bit)
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;

	// Translation stage that an invalidation targets
	localparam logic [1:0] KIND_S = 2'h0;
	localparam logic [1:0] KIND_VS = 2'h1;
	localparam logic [1:0] KIND_G = 2'h2;

	// Default sizes
	localparam int VA_WIDTH = 64;
	localparam int ID_WIDTH = 16;
	localparam int MAX_OUTSTANDING = 8;

	// Reset values
	localparam logic RST_READY = 1'b0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_STORES = 5'b00010,
		ST_ISSUE = 5'b00100,
		ST_DRAIN = 5'b01000,
		ST_RESP = 5'b10000
	} state_t;

endpackage

// *** testbench/fgi_cache_model.sv ***
// Behavioural translation cache model that takes requests and acks each after a delay
`timescale 1ns/10ps
module fgi_cache_model
(
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset
	input wire logic stall, // refuse requests
	input wire logic [3:0] ackDelay, // ack spacing
	input wire logic invValid, // request
	output logic invReady, // accepted
	output logic invAck, // one finished
	output logic [7:0] takenCount // requests taken
);
	logic [3:0] pend_reg, dly_reg;
	logic take, done;
	assign invReady = !stall;
	assign take = invValid && invReady;
	// Acks are serial, so a long delay keeps several entries outstanding
	assign done = pend_reg != 4'h0 && dly_reg == ackDelay;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			{pend_reg, dly_reg, invAck, takenCount} <= 17'h00000;
		else
		begin
			invAck <= done;
			dly_reg <= (pend_reg == 4'h0 || done) ? 4'h0 : dly_reg + 4'h1;
			pend_reg <= pend_reg + {3'h0, take} - {3'h0, done};
			takenCount <= takenCount + {7'h00, take};
		end
	end
endmodule

// *** testbench/fgi_sva.sv ***
// Port checker for the invalidate unit
`timescale 1ns/10ps
module fgi_sva
	import fg_inval_pkg::*;
#(
	parameter int VA_W = VA_WIDTH
)
(
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset
	input wire logic clkEn, // enable
	input wire logic opValid, // offer
	input wire logic [2:0] opCode, // op
	input wire logic [1:0] privLevel, // priv
	input wire logic virtMode, // virt
	input wire logic machine_trap_vm_ops, // trap bit
	input wire logic hyp_trap_guest_vm_ops, // trap bit
	input wire logic invReady, // accept
	input wire logic opReady, // ready
	input wire logic respValid, // done
	input wire logic respIllegal, // illegal
	input wire logic respVirtual, // virtual
	input wire logic invValid, // request
	input wire logic [1:0] invKind, // stage
	input wire logic [VA_W-1:0] invAddr, // address
	input wire logic walkHold // walk block
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic take, inS;
	assign take = clkEn && opValid && opReady;
	assign inS = take && privLevel == PRIV_S;
	////////////////////////////////////////////////////////////////
	a_u_illegal: assert property (take && privLevel == PRIV_U && !virtMode
		|-> ##[1:3] respValid && respIllegal && !respVirtual) else $error("U op");
	a_vu_virtual: assert property (take && privLevel == PRIV_U && virtMode
		|-> ##[1:3] respValid && respVirtual && !respIllegal) else $error("VU op");
	a_mtrap_illegal: assert property (inS && !virtMode && machine_trap_vm_ops &&
		(opCode == OP_SINVAL || opCode == OP_HINVAL_GVMA) |-> ##[1:3] respValid && respIllegal)
		else $error("machine trap op");
	a_vs_virtual: assert property (inS && virtMode && (opCode == OP_HINVAL_VVMA ||
		opCode == OP_HINVAL_GVMA || (opCode == OP_SINVAL && hyp_trap_guest_vm_ops))
		|-> ##[1:3] respValid && respVirtual) else $error("VS op");
	a_fence_free: assert property (inS && (opCode == OP_FENCE_W_INVAL ||
		opCode == OP_FENCE_INVAL_IR) |-> ##[1:60] respValid && !respIllegal && !respVirtual)
		else $error("fence trapped");
	a_sinval_issue: assert property (take && opCode == OP_SINVAL &&
		privLevel == PRIV_M |=> invValid) else $error("sinval late");
	a_req_stable: assert property (invValid && !invReady
		|=> invValid && $stable(invAddr) && $stable(invKind)) else $error("payload moved");
	a_hold_release: assert property ($fell(walkHold) |-> respValid)
		else $error("hold drop");
	c_virt: cover property (respValid && respVirtual);
	c_stall: cover property (invValid && !invReady);
	c_hold: cover property (walkHold);
endmodule

// *** testbench/fine_grained_translation_invalidate_tb.sv ***
// Self-checking bench for the invalidate unit
`timescale 1ns/10ps
module fine_grained_translation_invalidate_tb
	import fg_inval_pkg::*;
;
	logic core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, opValid = 1'b0, virtMode = 1'b0;
	logic machine_trap_vm_ops = 1'b0, hyp_trap_guest_vm_ops = 1'b0, stall = 1'b0;
	logic rs1Zero = 1'b1, rs2Zero = 1'b1, storesDrained = 1'b1;
	logic [2:0] opCode = 3'h0;
	logic [1:0] privLevel = 2'h3, invKind, gKind;
	logic [63:0] rs1Value = 64'h0000004012345000, invAddr, gAddr;
	logic [15:0] rs2Value = 16'h00A5, invId, gId;
	logic [3:0] ackDelay = 4'h2;
	logic [7:0] takenCount, base;
	logic invReady, invAck, opReady, respValid, respIllegal, respVirtual, invValid;
	logic invAllAddr, invAllId, walkHold, gHold, gAllA, gAllI, gIll, gVir;
	int n_fail = 0, n_tests = 0, gWait;
	fine_grained_translation_invalidate dut (.core_clk, .rst_n, .clkEn, .opValid, .opCode,
		.privLevel, .virtMode, .machine_trap_vm_ops, .hyp_trap_guest_vm_ops, .rs1Value,
		.rs1Zero, .rs2Value, .rs2Zero, .storesDrained, .invReady, .invAck, .opReady,
		.respValid, .respIllegal, .respVirtual, .invValid, .invKind, .invAddr, .invAllAddr,
		.invId, .invAllId, .walkHold);
	fgi_cache_model cache (.core_clk, .rst_n, .stall, .ackDelay, .invValid, .invReady,
		.invAck, .takenCount);
	initial
		forever #4 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (invValid && invReady)
			{gKind, gAddr, gAllA, gId, gAllI} <= {invKind, invAddr, invAllAddr, invId, invAllId};
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
			n_fail++;
		end
	endtask
	task automatic tick();
		@(negedge core_clk);
		gWait++;
		if (gWait > 99)
		begin
			n_fail++;
			wrap_up();
		end
	endtask
	// Offer one operation, hold it until taken, then wait for its completion pulse
	task automatic op(input logic [2:0] c, input logic [1:0] p, input logic v, input logic t,
		input logic h);
		@(negedge core_clk);
		{opCode, privLevel, virtMode, machine_trap_vm_ops, hyp_trap_guest_vm_ops} = {c, p, v, t, h};
		opValid = 1'b1;
		gWait = 0;
		while (opReady !== 1'b1)
			tick();
		@(negedge core_clk);
		opValid = 1'b0;
		gWait = 0;
		gHold = 1'b0;
		while (respValid !== 1'b1)
		begin
			gHold |= walkHold;
			tick();
		end
		{gIll, gVir} = {respIllegal, respVirtual};
	endtask
	// Every op in U, VU, HS with machine trap bit, VS with both trap bits
	task automatic t_modes();
		logic [1:0] md;
		logic [2:0] c;
		for (int m = 0; m < 32; m++)
		begin
			{md, c} = m[4:0];
			op(c, md[1] ? PRIV_S : PRIV_U, md[0], md[1], md == 2'h3);
			chk("illegal", md == 2'h0 || (md == 2'h2 && (c == OP_SINVAL ||
				c == OP_HINVAL_GVMA || c == OP_SFENCE_VMA || c == OP_HFENCE_GVMA)), gIll);
			chk("virtual", md == 2'h1 || (md == 2'h3 && c != OP_FENCE_W_INVAL &&
				c != OP_FENCE_INVAL_IR), gVir);
		end
	endtask
	// Bracketed batch with late stores, a stalled cache and slow acks
	task automatic t_batch();
		base = takenCount;
		// Stores late, slow acks, explicit operands, cache open
		{storesDrained, ackDelay, rs1Zero, rs2Zero, stall} = 8'h30;
		fork
			op(OP_FENCE_W_INVAL, PRIV_S, 1'b0, 1'b1, 1'b0);
			begin
				repeat (8) @(negedge core_clk);
				storesDrained = 1'b1;
			end
		join
		chk("store wait", 1'b1, gWait > 4);
		stall = 1'b1;
		fork
			op(OP_SINVAL, PRIV_M, 1'b0, 1'b1, 1'b1);
			begin
				repeat (5) @(negedge core_clk);
				stall = 1'b0;
			end
		join
		chk("kind", KIND_S, gKind);
		chk("addr", 64'h0000004012345000, gAddr);
		chk("id", 16'h00A5, gId);
		chk("all", 2'h0, {gAllA, gAllI});
		{rs1Zero, rs2Zero} = 2'h3;
		op(OP_HINVAL_GVMA, PRIV_M, 1'b0, 1'b0, 1'b0);
		chk("gvma kind", KIND_G, gKind);
		chk("gvma all", 2'h3, {gAllA, gAllI});
		chk("no wait", 1'b1, gWait < 3);
		op(OP_HINVAL_VVMA, PRIV_M, 1'b0, 1'b0, 1'b0);
		chk("vvma kind", KIND_VS, gKind);
		op(OP_SINVAL, PRIV_S, 1'b1, 1'b1, 1'b0);
		chk("vs sinval", 2'h0, {gIll, gVir});
		chk("vs kind", KIND_VS, gKind);
		op(OP_FENCE_INVAL_IR, PRIV_S, 1'b1, 1'b1, 1'b1);
		chk("walk held", 1'b1, gHold);
		chk("taken", 8'h04, takenCount - base);
	endtask
	initial
	begin
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		t_modes();
		t_batch();
		wrap_up();
	end
endmodule
bind fine_grained_translation_invalidate fgi_sva #(.VA_W(VA_W)) u_sva (.core_clk, .rst_n,
	.clkEn, .opValid, .opCode, .privLevel, .virtMode, .machine_trap_vm_ops,
	.hyp_trap_guest_vm_ops, .invReady, .opReady, .respValid, .respIllegal, .respVirtual,
	.invValid, .invKind, .invAddr, .walkHold);
